/* include/pwm_param_pkg.sv */
// Purpose: shared constants of the PWM shift parameter register bank
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package pwm_param_pkg;

	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned PARAM_W    = 16;
	localparam int unsigned TASK_W     = 4;
	localparam int unsigned STRB_W     = DATA_W / 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_SPEED_THRESH = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PERIOD_COPY  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MIN_PULSE    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS       = 8'h0C;

	// word alignment
	localparam int unsigned       ALIGN_LSB        = 2;
	localparam logic [1:0]        ALIGN_ZERO       = 2'h0;

	// reset values
	localparam logic [PARAM_W-1:0] PARAM_RESET     = 16'h0000;
	localparam logic [DATA_W-1:0]  WORD_ZERO       = 32'h0000_0000;

	// status field positions
	localparam int unsigned ST_LOW_SPEED      = 0;
	localparam int unsigned ST_LOW_SPEED_PREV = 1;
	localparam int unsigned ST_PULSE_SHORT    = 4;
	localparam int unsigned ST_PULSE_PREV     = 5;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// task numbers of the engine sequencer
	localparam logic [TASK_W-1:0] TASK_OUT_CTRL1 = 4'h0;
	localparam logic [TASK_W-1:0] TASK_TRIGGER   = 4'h1;
	localparam logic [TASK_W-1:0] TASK_OUT_CTRL2 = 4'h9;

	function automatic logic [PARAM_W-1:0] min2(input logic [PARAM_W-1:0] a, input logic [PARAM_W-1:0] b);
		min2 = (a < b) ? a : b;
	endfunction : min2

	function automatic logic [PARAM_W-1:0] max2(input logic [PARAM_W-1:0] a, input logic [PARAM_W-1:0] b);
		max2 = (a < b) ? b : a;
	endfunction : max2

endpackage : pwm_param_pkg

/* core/phase_spread.sv */
// Purpose: smallest duty and smallest disparity of the three phase compares
// Assumes: compares are unsigned counts of the pwm counter clock
// Notes:   purely combinational
module phase_spread
	import pwm_param_pkg::*;
(
	// phase compares
	input  wire logic [PARAM_W-1:0] phase_u_compare,
	input  wire logic [PARAM_W-1:0] phase_v_compare,
	input  wire logic [PARAM_W-1:0] phase_w_compare,
	// results
	output logic      [PARAM_W-1:0] min_duty,
	output logic      [PARAM_W-1:0] min_disparity
);

	wire logic [PARAM_W-1:0] lo_uv;
	wire logic [PARAM_W-1:0] hi_uv;
	wire logic [PARAM_W-1:0] lo_all;
	wire logic [PARAM_W-1:0] hi_all;
	wire logic [PARAM_W-1:0] mid_all;
	wire logic [PARAM_W-1:0] gap_low;
	wire logic [PARAM_W-1:0] gap_high;

	// sort three values
	assign lo_uv    = min2(phase_u_compare, phase_v_compare);
	assign hi_uv    = max2(phase_u_compare, phase_v_compare);
	assign lo_all   = min2(lo_uv, phase_w_compare);
	assign hi_all   = max2(hi_uv, phase_w_compare);
	assign mid_all  = max2(lo_uv, min2(hi_uv, phase_w_compare));

	// neighbouring gaps
	assign gap_low  = mid_all - lo_all;
	assign gap_high = hi_all - mid_all;

	assign min_duty      = lo_all;
	assign min_disparity = min2(gap_low, gap_high);

endmodule : phase_spread

/* core/flag_pair.sv */
// Purpose: one result flag with its previous value
// Assumes: update is a one-cycle pulse
// Notes:   previous value takes the old flag on every update
module flag_pair (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// update
	input  wire logic update,
	input  wire logic value,
	// state
	output logic      flag_q,
	output logic      prev_q
);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
			prev_q <= 1'b0;
		end else if (update) begin
			flag_q <= value;
			prev_q <= flag_q;
		end
	end

endmodule : flag_pair

/* core/motor_pwm_shift_param_regs.sv */
// Purpose: pwm shift parameter registers of the motor vector engine
// Assumes: task sequencer gives one-cycle task_start pulses with a task number
// Notes:   registers reached over AXI4-Lite; status word is read only
//
// Contract
// RULE1: speed threshold holds a 16-bit writable switching speed for pwm shift.
// RULE2: software writes threshold as switch Hz over max_rotation_speed times 2^15.
// RULE3: threshold consulted only in task 0, shift on, single shunt, method 1; the low_speed flag here compares it without method 1 too.
// RULE4: software loads period copy with the pwm timer unit period value.
// RULE5: stored period is used in tasks 0, 9 and 1.
// RULE6: task 0 shift single shunt: min pulse is least phase disparity reference.
// RULE7: task 9: min pulse is least phase duty reference.
// RULE8: task 0 shift single shunt: low speed flag set when speed below threshold.
// RULE9: bits 31-16 read zero, ignore writes; all zero after reset.
module motor_pwm_shift_param_regs
	import pwm_param_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// axi write address
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]          s_axi_awprot,
	// axi write data
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [DATA_W-1:0]   s_axi_wdata,
	input  wire logic [STRB_W-1:0]   s_axi_wstrb,
	// axi write response
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic      [1:0]          s_axi_bresp,
	// axi read address
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]          s_axi_arprot,
	// axi read data
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic      [DATA_W-1:0]   s_axi_rdata,
	output logic      [1:0]          s_axi_rresp,
	// task sequencer
	input  wire logic                task_start,
	input  wire logic [TASK_W-1:0]   task_id,
	input  wire logic                pwm_shift_en,
	input  wire logic                single_shunt,
	input  wire logic                shift_method1,
	input  wire logic [PARAM_W-1:0]  rotation_speed,
	input  wire logic [PARAM_W-1:0]  phase_u_compare,
	input  wire logic [PARAM_W-1:0]  phase_v_compare,
	input  wire logic [PARAM_W-1:0]  phase_w_compare,
	// parameters to the engine
	output logic      [PARAM_W-1:0]  task_period,
	output logic                     task_period_valid,
	output logic                     low_speed,
	output logic                     low_speed_prev,
	output logic                     shift1_low_speed,
	output logic                     pulse_short,
	output logic                     pulse_short_prev
);

	////////////////////////////////////////////////////////////////////////////
	// register storage

	logic [PARAM_W-1:0] speed_thresh_q;
	logic [PARAM_W-1:0] period_copy_q;
	logic [PARAM_W-1:0] min_pulse_q;

	////////////////////////////////////////////////////////////////////////////
	// write channel capture

	logic               aw_held_q;
	logic [ADDR_W-1:0]  aw_addr_q;
	logic               w_held_q;
	logic [DATA_W-1:0]  w_data_q;
	logic [STRB_W-1:0]  w_strb_q;
	logic               bvalid_q;
	logic [1:0]         bresp_q;

	wire logic          aw_take;
	wire logic          w_take;
	wire logic          aw_have;
	wire logic          w_have;
	wire logic [ADDR_W-1:0] wr_addr;
	wire logic [DATA_W-1:0] wr_data;
	wire logic [STRB_W-1:0] wr_strb;
	wire logic          wr_fire;
	wire logic          wr_aligned;
	wire logic          wr_thresh;
	wire logic          wr_period;
	wire logic          wr_minpls;
	wire logic          wr_status;
	wire logic          wr_hit;
	wire logic [PARAM_W-1:0] wr_mask;
	wire logic [PARAM_W-1:0] thresh_d;
	wire logic [PARAM_W-1:0] period_d;
	wire logic [PARAM_W-1:0] minpls_d;

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign aw_have       = aw_held_q || aw_take;
	assign w_have        = w_held_q || w_take;
	assign wr_fire       = aw_have && w_have && !bvalid_q;
	assign wr_addr       = aw_held_q ? aw_addr_q : s_axi_awaddr;
	assign wr_data       = w_held_q ? w_data_q : s_axi_wdata;
	assign wr_strb       = w_held_q ? w_strb_q : s_axi_wstrb;

	// address decode of the write
	assign wr_aligned = (wr_addr[ALIGN_LSB-1:0] == ALIGN_ZERO);
	assign wr_thresh  = wr_aligned && (wr_addr == OFS_SPEED_THRESH);
	assign wr_period  = wr_aligned && (wr_addr == OFS_PERIOD_COPY);
	assign wr_minpls  = wr_aligned && (wr_addr == OFS_MIN_PULSE);
	assign wr_status  = wr_aligned && (wr_addr == OFS_STATUS);
	assign wr_hit     = wr_thresh || wr_period || wr_minpls || wr_status;

	// only the low two byte lanes reach storage; upper lanes are dropped
	assign wr_mask  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};                       // [RULE9]
	assign thresh_d = (speed_thresh_q & ~wr_mask) | (wr_data[PARAM_W-1:0] & wr_mask);  // [RULE1]
	assign period_d = (period_copy_q & ~wr_mask) | (wr_data[PARAM_W-1:0] & wr_mask);
	assign minpls_d = (min_pulse_q & ~wr_mask) | (wr_data[PARAM_W-1:0] & wr_mask);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end else if (aw_take) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_held_q <= 1'b0;
			w_data_q <= WORD_ZERO;
			w_strb_q <= '0;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end else if (w_take) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	////////////////////////////////////////////////////////////////////////////
	// parameter registers

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_thresh_q <= PARAM_RESET;                                     // [RULE9]
			period_copy_q  <= PARAM_RESET;
			min_pulse_q    <= PARAM_RESET;
		end else if (wr_fire) begin
			if (wr_thresh) begin
				speed_thresh_q <= thresh_d;                                    // [RULE1]
			end
			if (wr_period) begin
				period_copy_q <= period_d;
			end
			if (wr_minpls) begin
				min_pulse_q <= minpls_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// task decode

	wire logic is_task0;
	wire logic is_task1;
	wire logic is_task9;
	wire logic shift_1shunt;
	wire logic speed_update;
	wire logic pulse_update;
	wire logic pulse_value;
	wire logic speed_below;
	wire logic [PARAM_W-1:0] min_duty;
	wire logic [PARAM_W-1:0] min_disparity;

	assign is_task0     = task_start && (task_id == TASK_OUT_CTRL1);
	assign is_task1     = task_start && (task_id == TASK_TRIGGER);
	assign is_task9     = task_start && (task_id == TASK_OUT_CTRL2);
	assign shift_1shunt = pwm_shift_en && single_shunt;

	// low speed judgement against the threshold
	assign speed_below  = rotation_speed < speed_thresh_q;                    // [RULE8]
	assign speed_update = is_task0 && shift_1shunt;                           // [RULE8]

	phase_spread u_spread (
		.phase_u_compare (phase_u_compare),
		.phase_v_compare (phase_v_compare),
		.phase_w_compare (phase_w_compare),
		.min_duty        (min_duty),
		.min_disparity   (min_disparity)
	);

	// disparity check in task 0, duty check in task 9
	assign pulse_update = (is_task0 && shift_1shunt) || is_task9;
	assign pulse_value  = is_task9 ? (min_duty < min_pulse_q)                 // [RULE7]
	                               : (min_disparity < min_pulse_q);           // [RULE6]

	flag_pair u_speed_flag (
		.clk    (clk),
		.rst_n  (rst_n),
		.update (speed_update),
		.value  (speed_below),
		.flag_q (low_speed),
		.prev_q (low_speed_prev)
	);

	flag_pair u_pulse_flag (
		.clk    (clk),
		.rst_n  (rst_n),
		.update (pulse_update),
		.value  (pulse_value),
		.flag_q (pulse_short),
		.prev_q (pulse_short_prev)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs to the engine

	logic [PARAM_W-1:0] task_period_q;
	logic               task_period_valid_q;
	logic               shift1_low_q;
	wire logic          period_task;

	assign period_task = is_task0 || is_task1 || is_task9;                    // [RULE5]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			task_period_q       <= PARAM_RESET;
			task_period_valid_q <= 1'b0;
		end else begin
			task_period_valid_q <= period_task;
			if (period_task) begin
				task_period_q <= period_copy_q;                                // [RULE5]
			end
		end
	end

	// threshold verdict for shift method 1 only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift1_low_q <= 1'b0;
		end else if (speed_update) begin
			shift1_low_q <= shift_method1 && speed_below;                      // [RULE3]
		end
	end

	assign task_period       = task_period_q;
	assign task_period_valid = task_period_valid_q;
	assign shift1_low_speed  = shift1_low_q;

	////////////////////////////////////////////////////////////////////////////
	// read channel

	logic               rvalid_q;
	logic [DATA_W-1:0]  rdata_q;
	logic [1:0]         rresp_q;
	wire logic          ar_take;
	wire logic          rd_aligned;
	wire logic          rd_hit;
	wire logic [DATA_W-1:0] status_word;
	wire logic [DATA_W-1:0] rd_word;

	assign s_axi_arready = !rvalid_q;
	assign ar_take       = s_axi_arvalid && s_axi_arready;
	assign rd_aligned    = (s_axi_araddr[ALIGN_LSB-1:0] == ALIGN_ZERO);

	assign status_word = WORD_ZERO
		| (DATA_W'(low_speed)        << ST_LOW_SPEED)
		| (DATA_W'(low_speed_prev)   << ST_LOW_SPEED_PREV)
		| (DATA_W'(pulse_short)      << ST_PULSE_SHORT)
		| (DATA_W'(pulse_short_prev) << ST_PULSE_PREV);

	// upper half of every parameter word reads zero
	assign rd_hit  = rd_aligned && ((s_axi_araddr == OFS_SPEED_THRESH) || (s_axi_araddr == OFS_PERIOD_COPY)
	                 || (s_axi_araddr == OFS_MIN_PULSE) || (s_axi_araddr == OFS_STATUS));
	assign rd_word = !rd_aligned                      ? WORD_ZERO
	               : (s_axi_araddr == OFS_SPEED_THRESH) ? DATA_W'(speed_thresh_q)    // [RULE9]
	               : (s_axi_araddr == OFS_PERIOD_COPY)  ? DATA_W'(period_copy_q)
	               : (s_axi_araddr == OFS_MIN_PULSE)    ? DATA_W'(min_pulse_q)
	               : (s_axi_araddr == OFS_STATUS)       ? status_word
	               : WORD_ZERO;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= WORD_ZERO;
			rresp_q  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

endmodule : motor_pwm_shift_param_regs

/* sim/pwm_regs_assertions.sv */
// Purpose: port assertions of the pwm shift parameter registers
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound onto the top module at the foot of this file
module pwm_regs_assertions
	import pwm_param_pkg::*;
(
	// clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// register bus
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic [DATA_W-1:0]  s_axi_rdata,
	// task side
	input wire logic               task_start,
	input wire logic [TASK_W-1:0]  task_id,
	input wire logic               pwm_shift_en,
	input wire logic               single_shunt,
	input wire logic               shift_method1,
	input wire logic [PARAM_W-1:0] rotation_speed,
	input wire logic               task_period_valid,
	input wire logic               low_speed,
	input wire logic               low_speed_prev,
	input wire logic               shift1_low_speed,
	input wire logic               pulse_short,
	input wire logic               pulse_short_prev
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	wire period_id = task_id == TASK_OUT_CTRL1 || task_id == TASK_TRIGGER || task_id == TASK_OUT_CTRL2;
	wire flag_id   = (task_id == TASK_OUT_CTRL1 && pwm_shift_en && single_shunt) || task_id == TASK_OUT_CTRL2;
	sequence t0_upd;
		task_start && task_id == TASK_OUT_CTRL1 && pwm_shift_en && single_shunt;
	endsequence
	sequence t9_upd;
		task_start && task_id == TASK_OUT_CTRL2;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	period_pulse_a: assert property (task_start && period_id |=> task_period_valid)
		else $error("period not delivered");
	period_quiet_a: assert property (task_start && !period_id |=> !task_period_valid)
		else $error("period pulse on other task");
	flag_still_a: assert property (task_start && !flag_id |=> $stable({low_speed, low_speed_prev, pulse_short}))
		else $error("flag changed on other task");
	speed_max_a: assert property (t0_upd ##0 rotation_speed == 16'hFFFF |=> !low_speed)
		else $error("full speed flagged low");
	speed_prev_a: assert property (t0_upd |=> low_speed_prev == $past(low_speed))
		else $error("low speed history wrong");
	method_gate_a: assert property (t0_upd ##0 !shift_method1 |=> !shift1_low_speed)
		else $error("threshold used without method 1");
	pulse_prev_a: assert property (t0_upd or t9_upd |=> pulse_short_prev == $past(pulse_short))
		else $error("pulse flag history wrong");
endmodule : pwm_regs_assertions

bind motor_pwm_shift_param_regs pwm_regs_assertions u_chk (.*);

/* sim/task_seq_model.sv */
// Purpose: task sequencer of the vector engine
// Assumes: one-cycle start pulse, fields valid with it
// Notes:   id, speed and compares are inverted once the pulse is over; mode bits hold
module task_seq_model
	import pwm_param_pkg::*;
(
	// clock
	input  wire logic               clk,
	// task port
	output logic                    task_start,
	output logic [TASK_W-1:0]       task_id,
	output logic                    pwm_shift_en,
	output logic                    single_shunt,
	output logic                    shift_method1,
	output logic [PARAM_W-1:0]      rotation_speed,
	output logic [PARAM_W-1:0]      phase_u_compare,
	output logic [PARAM_W-1:0]      phase_v_compare,
	output logic [PARAM_W-1:0]      phase_w_compare
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		task_start = 1'h0;
		{task_id, pwm_shift_en, single_shunt, shift_method1} = 7'h00;
		{rotation_speed, phase_u_compare, phase_v_compare, phase_w_compare} = 64'h0;
	end
	// one task: mode is shift enable, single shunt, method 1
	task run_task(input logic [TASK_W-1:0] id, input logic [2:0] m, input logic [PARAM_W-1:0] sp, u, v, w);
		@(posedge clk);
		task_id <= id;
		{pwm_shift_en, single_shunt, shift_method1} <= m;
		{rotation_speed, phase_u_compare, phase_v_compare, phase_w_compare} <= {sp, u, v, w};
		task_start <= 1'h1;
		@(posedge clk);
		task_start <= 1'h0;
		task_id <= ~id;
		{rotation_speed, phase_u_compare, phase_v_compare, phase_w_compare} <= ~{sp, u, v, w};
	endtask : run_task
endmodule : task_seq_model

/* sim/motor_pwm_shift_param_regs_tb.sv */
// Purpose: self-checking bench of the pwm shift parameter registers
// Assumes: sequencer model drives the task port
// Notes:   register and task cases are table rows
module motor_pwm_shift_param_regs_tb
	import pwm_param_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] q; logic [1:0] r;} reg_row_t;
	typedef struct {logic [3:0] id; logic [2:0] m; logic [15:0] sp, u, v, w; logic [5:0] f;} task_row_t;
	logic              clk = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic              rready = 1'h0, awready, wready, bvalid, arready, rvalid, tstart, shen, sshunt, m1;
	logic              tpv, ls, lsp, s1ls, ps, psp;
	logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]       wdata = 32'h0, rdata, q;
	logic [3:0]        wstrb = 4'h0, tid;
	logic [1:0]        bresp, rresp, r;
	logic [15:0]       speed, cu, cv, cw, tper;
	int                err_count = 0, tests_run = 0, cycles = 0;
	reg_row_t          rr[7];
	task_row_t         tr[8];
	always #20 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	task_seq_model seq (.clk(clk), .task_start(tstart), .task_id(tid), .pwm_shift_en(shen), .single_shunt(sshunt),
		.shift_method1(m1), .rotation_speed(speed), .phase_u_compare(cu), .phase_v_compare(cv), .phase_w_compare(cw));
	motor_pwm_shift_param_regs dut (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .task_start(tstart),
		.task_id(tid), .pwm_shift_en(shen), .single_shunt(sshunt), .shift_method1(m1), .rotation_speed(speed),
		.phase_u_compare(cu), .phase_v_compare(cv), .phase_w_compare(cw), .task_period(tper),
		.task_period_valid(tpv), .low_speed(ls), .low_speed_prev(lsp), .shift1_low_speed(s1ls), .pulse_short(ps),
		.pulse_short_prev(psp));
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
		@(posedge clk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		rs = 2'hx;
		repeat (50) begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) begin
				rs = bresp;
				break;
			end
		end
		bready <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		{d, rs} = 34'hx;
		repeat (50) begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) begin
				{d, rs} = {rdata, rresp};
				break;
			end
		end
		rready <= 1'h0;
	endtask : rd
	task report_and_stop;
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		// threshold 1000 Hz of 4000 Hz max is 0x2000
		rr = '{'{8'h00, 32'hFFFF2000, 4'hF, 32'h2000, RESP_OKAY}, '{8'h04, 32'hABCD0FA0, 4'hF, 32'h0FA0, RESP_OKAY},
			'{8'h08, 32'h00000010, 4'h1, 32'h0010, RESP_OKAY}, '{8'h08, 32'h00FF3300, 4'h4, 32'h0010, RESP_OKAY},
			'{8'h0C, 32'hFFFFFFFF, 4'hF, 32'h0000, RESP_OKAY}, '{8'h10, 32'h12345678, 4'hF, 32'h0, RESP_DECERR},
			'{8'h02, 32'h12345678, 4'hF, 32'h0, RESP_DECERR}};
		// flags: period valid, low speed, prev, method 1 low, pulse short, prev
		tr = '{'{4'h1, 3'h0, 16'h0, 16'd0, 16'd0, 16'd0, 6'h20}, '{4'h0, 3'h7, 16'h1FFF, 16'd100, 16'd105, 16'd300, 6'h36},
			'{4'h0, 3'h6, 16'h2000, 16'd100, 16'd200, 16'd300, 6'h29}, '{4'h0, 3'h3, 16'h0, 16'd0, 16'd9, 16'd9, 6'h29},
			'{4'h9, 3'h0, 16'h0, 16'd15, 16'd400, 16'd500, 6'h2A}, '{4'h9, 3'h7, 16'h0, 16'd16, 16'd16, 16'd16, 6'h29},
			'{4'h5, 3'h7, 16'h0, 16'd0, 16'd1, 16'd90, 6'h09}, '{4'h0, 3'h7, 16'hFFFF, 16'd0, 16'd0, 16'd0, 6'h22}};
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		foreach (rr[i]) begin
			wr(rr[i].a, rr[i].d, rr[i].s, r);
			chk({30'h0, r}, {30'h0, rr[i].r});
			rd(rr[i].a, q, r);
			chk(q, rr[i].q);
			chk({30'h0, r}, {30'h0, rr[i].r});
		end
		foreach (tr[i]) begin
			seq.run_task(tr[i].id, tr[i].m, tr[i].sp, tr[i].u, tr[i].v, tr[i].w);
			#1;
			chk({10'h0, tper, tpv, ls, lsp, s1ls, ps, psp}, {10'h0, 16'h0FA0, tr[i].f});
		end
		rd(OFS_STATUS, q, r);
		chk(q, 32'h10);
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		#1;
		chk({10'h0, tper, tpv, ls, lsp, s1ls, ps, psp}, 32'h0);
		for (int a = 0; a < 16; a += 4) begin
			rd(8'(a), q, r);
			chk(q, 32'h0);
		end
		report_and_stop();
	end
endmodule : motor_pwm_shift_param_regs_tb
